// ---- logic/test_port_defines.svh ----
`ifndef TEST_PORT_DEFINES_SVH
`define TEST_PORT_DEFINES_SVH

// core clock
`define CLK_HZ              200000000
// float-mode entry threshold in port clock edges
`define FLOAT_EDGE_COUNT    6'd33
`define FLOAT_CNT_W         6
// number of device pins whose drivers the float mode takes over
`define NUM_PINS            8
// pin synchroniser reset levels: {ref, rx, shift clock, select_n}
`define SYNC_RESET          4'h1

// forced-transmit control byte layout
`define FORCE_EN_BIT        7
`define FORCE_SEL_HI        3
`define FORCE_SEL_LO        0

// link configuration byte: role toggle bit and role after reset (1 = master)
`define LINK_ROLE_BIT       1
`define LINK_MASTER_RESET   1'b1

// line symbol rate and tone figures
`define BAUD_HZ             80000
`define SYM_TICK_CYCLES     (`CLK_HZ / `BAUD_HZ)
`define SYM_DIV_W           12
`define TONE10K_HZ          10000
`define TONE10K_HALF_SYMS   (`BAUD_HZ / `TONE10K_HZ / 2)
`define TONE40K_HZ          40000
`define TONE40K_HALF_SYMS   (`BAUD_HZ / `TONE40K_HZ / 2)
`define TONE_CNT_W          3

// 2b1q quat codes
`define QUAT_P3             2'h2
`define QUAT_P1             2'h3
`define QUAT_M1             2'h1
`define QUAT_M3             2'h0

// oscillator trim array
`define CAP_W               8
`define CAP_MIN             8'h00
`define CAP_CENTER          8'h80
`define CAP_MAX             8'hff

// trim reference: nominal rate, slowest rate that already counts as overrange
`define REF_NOMINAL_HZ      8000
`define REF_OVERRANGE_HZ    8001
`define REF_STATIC_PERIODS  2
`define REF_NOMINAL_CYCLES  (`CLK_HZ / `REF_NOMINAL_HZ)
`define REF_OVERRANGE_CYCLES (`CLK_HZ / `REF_OVERRANGE_HZ)
`define REF_STATIC_CYCLES   (`REF_STATIC_PERIODS * `REF_NOMINAL_CYCLES)
`define REF_CNT_W           17

// oscillator copies made by phase accumulators
`define ACC_W               24
`define OSC_HZ              20480000
`define CLK4096_HZ          4096000
`define OSC_INC             (64'd16777216 * `OSC_HZ / `CLK_HZ)
`define CLK4096_INC         (64'd16777216 * `CLK4096_HZ / `CLK_HZ)

`endif

// ---- logic/test_port_pkg.sv ----
package test_port_pkg;

  // float-mode entry sequencer
  typedef enum logic [2:0] {
    FLOAT_IDLE  = 3'b001,
    FLOAT_COUNT = 3'b010,
    FLOAT_ON    = 3'b100
  } float_state_t;

  // forced transmit signal selection
  typedef enum logic [3:0] {
    FORCE_SL0      = 4'h0,
    FORCE_SL1      = 4'h1,
    FORCE_SL2      = 4'h2,
    FORCE_SL3      = 4'h3,
    FORCE_SN0      = 4'h4,
    FORCE_TN       = 4'h5,
    FORCE_SN1      = 4'h6,
    FORCE_SN2      = 4'h7,
    FORCE_SN3      = 4'h8,
    FORCE_TONE10K  = 4'h9,
    FORCE_TONE40K  = 4'ha,
    FORCE_ALT_QUAT = 4'hb
  } force_sel_t;

  typedef logic [1:0] quat_t;

endpackage

// ---- logic/symbol_if.sv ----
`timescale 1ns/1ps
`default_nettype none

// carries the symbol-rate strobe and tone selection to the tone source
interface symbol_if;
  logic                     tick;
  test_port_pkg::force_sel_t sel;
  test_port_pkg::quat_t     quat;
  logic                     is_tone;

  modport src  (input tick, input sel, output quat, output is_tone);
  modport sink (output tick, output sel, input quat, input is_tone);
endinterface

`default_nettype wire

// ---- logic/forced_tone_gen.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "test_port_defines.svh"

module forced_tone_gen (
  input  wire logic   i_clk,    // core clock
  input  wire logic   i_reset,  // synchronous reset, active high
  symbol_if.src       sym       // symbol strobe in, quat out
);

  logic [`TONE_CNT_W-1:0] cnt_q;
  logic [`TONE_CNT_W-1:0] cnt_d;
  logic                   phase_q;
  logic                   phase_d;
  logic [`TONE_CNT_W-1:0] half_len;
  logic                   sel_10k;
  logic                   sel_40k;
  logic                   sel_alt;

  // the three locally made signals; the rest come from the framer itself
  assign sel_10k     = (sym.sel == test_port_pkg::FORCE_TONE10K);
  assign sel_40k     = (sym.sel == test_port_pkg::FORCE_TONE40K);
  assign sel_alt     = (sym.sel == test_port_pkg::FORCE_ALT_QUAT);
  assign sym.is_tone = sel_10k | sel_40k | sel_alt;
  assign half_len    = sel_10k ? `TONE_CNT_W'(`TONE10K_HALF_SYMS) : `TONE_CNT_W'(`TONE40K_HALF_SYMS);
  assign cnt_d       = (sel_alt || cnt_q == half_len - `TONE_CNT_W'(1)) ? '0 : cnt_q + `TONE_CNT_W'(1);
  assign phase_d     = (sel_alt || cnt_q == half_len - `TONE_CNT_W'(1)) ? ~phase_q : phase_q;

  // tones swing full scale; alternating quats use the inner levels
  assign sym.quat = sel_alt ? (phase_q ? `QUAT_P1 : `QUAT_M1)
                            : (phase_q ? `QUAT_P3 : `QUAT_M3);

  // advance once per line symbol so the tone frequencies are exact
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cnt_q   <= '0;
      phase_q <= 1'b1;
    end else if (sym.tick) begin
      cnt_q   <= cnt_d;
      phase_q <= phase_d;
    end
  end

endmodule // forced_tone_gen

`default_nettype wire

// ---- logic/transceiver_test_modes.sv ----
// Notes on behaviour
// - 33 clock edges, select low, receive high: float
// - float mode disables every output driver
// - select high or receive low leaves float
// - force byte hands framer to controller
// - forced signals: SL, SN, TN, tones, quats
// - network side, deactivated: trim array centered
// - line side, static reference: trim array maximum
// - line side, overrange reference: trim array minimum
// - buffered oscillator copy unless switched off
// - 4096 kHz clock output from oscillator
// - link config bit one toggles master/slave
`timescale 1ns/1ps
`default_nettype none
`include "test_port_defines.svh"

module transceiver_test_modes #(
  parameter int REF_NOMINAL_CYCLES   = `REF_NOMINAL_CYCLES,    // reference period at nominal rate
  parameter int REF_OVERRANGE_CYCLES = `REF_OVERRANGE_CYCLES,  // period at or below which ref is overrange
  parameter int REF_STATIC_CYCLES    = `REF_STATIC_CYCLES      // no edge this long: reference static
) (
  input  wire logic                  i_clk,                 // 200 MHz core clock
  input  wire logic                  i_reset,               // synchronous reset, active high
  input  wire logic                  i_port_select_n,       // control port enable pin, low active
  input  wire logic                  i_port_shift_clock,    // control port clock pin
  input  wire logic                  i_port_receive_in,     // control port receive pin
  input  wire logic                  i_trim_reference_in,   // frequency reference pin
  input  wire logic                  i_network_side_mode,   // 1 network side, 0 line side
  input  wire logic                  i_transceiver_active,  // transceiver activated
  input  wire logic                  i_buffered_osc_off,    // switch off buffered oscillator pin
  input  wire logic [7:0]            i_transmit_force_byte, // forced transmit control byte
  input  wire logic [7:0]            i_link_config_byte,    // link configuration byte
  input  wire logic                  i_link_config_wr,      // config byte write strobe
  input  wire logic [`NUM_PINS-1:0]  i_pin_drive_en,        // core wishes to drive each pin
  input  wire logic [1:0]            i_framer_quat,         // quat from superframe framer
  output logic                       o_all_outputs_float_mode, // float mode active
  output logic [`NUM_PINS-1:0]       o_pin_oe,              // pin output enables
  output logic                       o_force_active,        // framer under controller command
  output logic [3:0]                 o_framer_select,       // signal the framer must make
  output logic [1:0]                 o_tx_quat,             // quat to the line driver
  output logic                       o_tx_oe,               // line driver enable
  output logic [`CAP_W-1:0]          o_cap_array,           // oscillator trim capacitance
  output logic                       o_buffered_osc_out,    // buffered oscillator copy
  output logic                       o_buffered_osc_oe,     // its output enable
  output logic                       o_clk_4096_out,        // 4096 kHz clock
  output logic                       o_clk_4096_oe,         // its output enable
  output logic                       o_tdm_link_master      // 1 master on data link
);

  // ---------------- pin synchronisers ----------------
  logic [3:0] pins_in;
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic [3:0] sync3_q;
  logic [3:0] filt_q;
  logic [3:0] filt_d;

  assign pins_in = {i_trim_reference_in, i_port_receive_in, i_port_shift_clock, i_port_select_n};

  // three stages per pin; a level is accepted only once stages two and three agree
  localparam logic [3:0] SYNC_RST = `SYNC_RESET;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      assign filt_d[gi] = (sync2_q[gi] == sync3_q[gi]) ? sync3_q[gi] : filt_q[gi];
      always_ff @(posedge i_clk) begin
        if (i_reset) begin
          sync1_q[gi] <= SYNC_RST[gi];
          sync2_q[gi] <= SYNC_RST[gi];
          sync3_q[gi] <= SYNC_RST[gi];
          filt_q[gi]  <= SYNC_RST[gi];
        end else begin
          sync1_q[gi] <= pins_in[gi];
          sync2_q[gi] <= sync1_q[gi];
          sync3_q[gi] <= sync2_q[gi];
          filt_q[gi]  <= filt_d[gi];
        end
      end
    end
  endgenerate

  // ---------------- float mode entry and exit ----------------
  test_port_pkg::float_state_t state_q;
  test_port_pkg::float_state_t state_d;
  logic [`FLOAT_CNT_W-1:0]     edges_q;
  logic [`FLOAT_CNT_W-1:0]     edges_d;
  logic                        shift_rise;
  logic                        armed;

  assign shift_rise = filt_d[1] & ~filt_q[1];
  assign armed      = ~filt_d[0] & filt_d[2];     // select low while receive high

  // any break in the pin pattern drops the partial count, so stray edges never add up
  always_comb begin
    state_d = state_q;
    edges_d = edges_q;
    case (state_q)
      test_port_pkg::FLOAT_IDLE: begin
        edges_d = '0;
        if (armed && shift_rise) begin
          state_d = test_port_pkg::FLOAT_COUNT;
          edges_d = `FLOAT_CNT_W'(1);
        end
      end
      test_port_pkg::FLOAT_COUNT: begin
        if (!armed) begin
          state_d = test_port_pkg::FLOAT_IDLE;
          edges_d = '0;
        end else if (shift_rise) begin
          edges_d = edges_q + `FLOAT_CNT_W'(1);
          if (edges_d == `FLOAT_EDGE_COUNT) begin
            state_d = test_port_pkg::FLOAT_ON;
          end
        end
      end
      test_port_pkg::FLOAT_ON: begin
        if (!armed) begin
          state_d = test_port_pkg::FLOAT_IDLE;
          edges_d = '0;
        end
      end
      default: begin
        state_d = test_port_pkg::FLOAT_IDLE;
        edges_d = '0;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_q <= test_port_pkg::FLOAT_IDLE;
      edges_q <= '0;
    end else begin
      state_q <= state_d;
      edges_q <= edges_d;
    end
  end

  logic floating;
  assign floating = (state_d == test_port_pkg::FLOAT_ON);

  // ---------------- forced transmit ----------------
  symbol_if sym ();
  logic [`SYM_DIV_W-1:0] sym_div_q;
  logic                  sym_tick_q;
  logic                  force_en;
  logic [1:0]            tx_quat_d;

  assign force_en = i_transmit_force_byte[`FORCE_EN_BIT];
  assign sym.sel  = test_port_pkg::force_sel_t'(i_transmit_force_byte[`FORCE_SEL_HI:`FORCE_SEL_LO]);
  assign sym.tick = sym_tick_q;

  // one-cycle strobe at the line symbol rate
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      sym_div_q  <= '0;
      sym_tick_q <= 1'b0;
    end else begin
      sym_tick_q <= (sym_div_q == `SYM_DIV_W'(`SYM_TICK_CYCLES - 1));
      sym_div_q  <= (sym_div_q == `SYM_DIV_W'(`SYM_TICK_CYCLES - 1)) ? '0 : sym_div_q + `SYM_DIV_W'(1);
    end
  end

  forced_tone_gen u_tone (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .sym     (sym.src)
  );

  // forced signals ignore the receiver entirely; tones and alternating quats come from here, line codes from the framer
  assign tx_quat_d = (force_en && sym.is_tone) ? sym.quat : i_framer_quat;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_force_active  <= 1'b0;
      o_framer_select <= 4'h0;
      o_tx_quat       <= `QUAT_M3;
    end else begin
      o_force_active  <= force_en;
      o_framer_select <= sym.sel;
      o_tx_quat       <= tx_quat_d;
    end
  end

  // ---------------- oscillator trim loop ----------------
  logic [`REF_CNT_W-1:0] ref_cnt_q;
  logic                  ref_rise;
  logic                  ref_static;
  logic                  ref_fast;
  logic                  ref_slow;
  logic [`CAP_W-1:0]     cap_d;

  assign ref_rise   = filt_d[3] & ~filt_q[3];
  assign ref_static = (ref_cnt_q >= `REF_CNT_W'(REF_STATIC_CYCLES));
  assign ref_fast   = (ref_cnt_q <= `REF_CNT_W'(REF_OVERRANGE_CYCLES));
  assign ref_slow   = (ref_cnt_q > `REF_CNT_W'(REF_NOMINAL_CYCLES));

  // a slow reference asks for a slower oscillator: more capacitance, and the reverse
  always_comb begin
    cap_d = o_cap_array;
    if (i_network_side_mode) begin
      if (!i_transceiver_active) begin
        cap_d = `CAP_CENTER;
      end
    end else if (ref_static) begin
      cap_d = `CAP_MAX;
    end else if (ref_rise) begin
      if (ref_fast) begin
        cap_d = `CAP_MIN;
      end else if (ref_slow && o_cap_array != `CAP_MAX) begin
        cap_d = o_cap_array + `CAP_W'(1);
      end else if (!ref_slow && o_cap_array != `CAP_MIN) begin
        cap_d = o_cap_array - `CAP_W'(1);
      end
    end
  end

  // period counter saturates so a stuck reference holds the static verdict
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ref_cnt_q   <= '0;
      o_cap_array <= `CAP_CENTER;
    end else begin
      ref_cnt_q   <= ref_rise ? '0 : (ref_static ? ref_cnt_q : ref_cnt_q + `REF_CNT_W'(1));
      o_cap_array <= cap_d;
    end
  end

  // ---------------- oscillator copies ----------------
  logic [`ACC_W-1:0] osc_acc_q;
  logic [`ACC_W-1:0] c4096_acc_q;

  // phase accumulators: edge jitter is one core cycle, average rate slightly low from the truncated increment
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      osc_acc_q   <= '0;
      c4096_acc_q <= '0;
    end else begin
      osc_acc_q   <= osc_acc_q + `ACC_W'(`OSC_INC);
      c4096_acc_q <= c4096_acc_q + `ACC_W'(`CLK4096_INC);
    end
  end

  // ---------------- link role ----------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_tdm_link_master <= `LINK_MASTER_RESET;
    end else if (i_link_config_wr && i_link_config_byte[`LINK_ROLE_BIT]) begin
      o_tdm_link_master <= ~o_tdm_link_master;
    end
  end

  // ---------------- pin drivers, all silenced by float mode ----------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_all_outputs_float_mode <= 1'b0;
      o_pin_oe                 <= '0;
      o_tx_oe                  <= 1'b0;
      o_buffered_osc_out       <= 1'b0;
      o_buffered_osc_oe        <= 1'b0;
      o_clk_4096_out           <= 1'b0;
      o_clk_4096_oe            <= 1'b0;
    end else begin
      o_all_outputs_float_mode <= floating;
      o_pin_oe                 <= floating ? '0 : i_pin_drive_en;
      o_tx_oe                  <= ~floating;
      o_buffered_osc_out       <= osc_acc_q[`ACC_W-1];
      o_buffered_osc_oe        <= ~floating & ~i_buffered_osc_off;
      o_clk_4096_out           <= c4096_acc_q[`ACC_W-1];
      o_clk_4096_oe            <= ~floating;
    end
  end

endmodule // transceiver_test_modes

`default_nettype wire

// ---- testbench/transceiver_test_modes_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "test_port_defines.svh"

module transceiver_test_modes_asserts #(
  parameter int REF_OVERRANGE_CYCLES = 99,  // overrange period
  parameter int REF_STATIC_CYCLES    = 200  // static timeout
) (
  input wire logic              i_clk,                    // clock
  input wire logic              i_reset,                  // reset
  input wire logic              i_port_select_n,          // pin
  input wire logic              i_port_shift_clock,       // pin
  input wire logic              i_port_receive_in,        // pin
  input wire logic              i_trim_reference_in,      // pin
  input wire logic              i_network_side_mode,      // mode
  input wire logic              i_transceiver_active,     // active
  input wire logic [7:0]        i_transmit_force_byte,    // force
  input wire logic [7:0]        i_link_config_byte,       // config
  input wire logic              i_link_config_wr,         // strobe
  input wire logic              o_all_outputs_float_mode, // float
  input wire logic [7:0]        o_pin_oe,                 // enables
  input wire logic              o_force_active,           // forced
  input wire logic [3:0]        o_framer_select,          // select
  input wire logic              o_tx_oe,                  // line oe
  input wire logic [`CAP_W-1:0] o_cap_array,              // trim
  input wire logic              o_buffered_osc_oe,        // osc oe
  input wire logic              o_clk_4096_oe,            // clock oe
  input wire logic              o_tdm_link_master         // role
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);

  logic sclk_q, ref_q, seen_q;
  int   edge_cnt_q, static_cnt_q, period_q;
  wire  armed     = ~i_port_select_n & i_port_receive_in;
  wire  sclk_rise = i_port_shift_clock & ~sclk_q;
  wire  ref_rise  = i_trim_reference_in & ~ref_q;
  wire  role_wr   = i_link_config_wr & i_link_config_byte[1];

  // raw pin counts; the design filters the pins, so checks leave slack
  always_ff @(posedge i_clk) begin
    sclk_q <= i_port_shift_clock;
    ref_q  <= i_trim_reference_in;
    if (i_reset || !armed) edge_cnt_q <= 0;
    else if (sclk_rise && edge_cnt_q < 63) edge_cnt_q <= edge_cnt_q + 1;
    if (i_reset || i_network_side_mode || i_trim_reference_in != ref_q) static_cnt_q <= 0;
    else if (static_cnt_q < 100000) static_cnt_q <= static_cnt_q + 1;
    if (i_reset || i_network_side_mode) seen_q <= 1'b0;
    else if (ref_rise) seen_q <= 1'b1;
    if (ref_rise) period_q <= 1;
    else if (period_q < 100000) period_q <= period_q + 1;
  end

  sequence seq_armed_run;
    armed [*8];
  endsequence
  sequence seq_fast_edge;
    ref_rise && seen_q && !i_network_side_mode && period_q <= REF_OVERRANGE_CYCLES - 2;
  endsequence

  a_float_entry_due: assert property (edge_cnt_q >= 33 ##1 seq_armed_run |-> o_all_outputs_float_mode)
    else $error("float mode not entered after threshold");
  a_float_not_early: assert property ($rose(o_all_outputs_float_mode) |-> edge_cnt_q >= 33)
    else $error("float mode entered before threshold");
  a_float_drops_oe: assert property (o_all_outputs_float_mode |-> o_pin_oe == 8'h00 && !o_tx_oe && !o_buffered_osc_oe && !o_clk_4096_oe)
    else $error("output enabled in float mode");
  a_float_exit: assert property (o_all_outputs_float_mode && !armed ##1 (!armed) [*5] |=> !o_all_outputs_float_mode)
    else $error("float mode not left");
  a_force_follow: assert property (!$past(i_reset) |-> o_force_active == $past(i_transmit_force_byte[7]) && o_framer_select == $past(i_transmit_force_byte[3:0]))
    else $error("force outputs do not follow byte");
  a_role_toggle: assert property (role_wr |=> o_tdm_link_master != $past(o_tdm_link_master))
    else $error("role did not toggle");
  a_role_hold: assert property (!role_wr |=> $stable(o_tdm_link_master))
    else $error("role changed without write");
  a_trim_center: assert property (i_network_side_mode && !i_transceiver_active |=> o_cap_array == 8'h80)
    else $error("trim not centered");
  a_trim_static_max: assert property (static_cnt_q >= REF_STATIC_CYCLES + 8 |-> o_cap_array == 8'hff)
    else $error("trim not at maximum");
  a_trim_fast_min: assert property (seq_fast_edge |-> ##[1:10] o_cap_array == 8'h00)
    else $error("trim not at minimum");
endmodule // transceiver_test_modes_asserts

bind transceiver_test_modes transceiver_test_modes_asserts #(
  .REF_OVERRANGE_CYCLES(REF_OVERRANGE_CYCLES), .REF_STATIC_CYCLES(REF_STATIC_CYCLES)
) i_transceiver_test_modes_asserts (
  .i_clk(i_clk), .i_reset(i_reset), .i_port_select_n(i_port_select_n),
  .i_port_shift_clock(i_port_shift_clock), .i_port_receive_in(i_port_receive_in),
  .i_trim_reference_in(i_trim_reference_in), .i_network_side_mode(i_network_side_mode),
  .i_transceiver_active(i_transceiver_active), .i_transmit_force_byte(i_transmit_force_byte),
  .i_link_config_byte(i_link_config_byte), .i_link_config_wr(i_link_config_wr),
  .o_all_outputs_float_mode(o_all_outputs_float_mode), .o_pin_oe(o_pin_oe),
  .o_force_active(o_force_active), .o_framer_select(o_framer_select), .o_tx_oe(o_tx_oe),
  .o_cap_array(o_cap_array), .o_buffered_osc_oe(o_buffered_osc_oe),
  .o_clk_4096_oe(o_clk_4096_oe), .o_tdm_link_master(o_tdm_link_master)
);

`default_nettype wire

// ---- testbench/port_controller_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// stands in for the controller on the serial control port pins
module port_controller_model (
  input  wire logic i_clk,         // core clock
  output var  logic o_select_n,    // port enable, low active
  output var  logic o_shift_clock, // port clock
  output var  logic o_receive_in   // port receive, pulled up
);
  // idle: deselected, clock parked low, receive at its pull-up level
  initial begin
    o_select_n    = 1'b1;
    o_shift_clock = 1'b0;
    o_receive_in  = 1'b1;
  end

  // level pins move just after an edge, with the clock parked low
  task automatic set_pins(input logic sel_n, input logic rx);
    @(posedge i_clk);
    o_select_n   <= sel_n;
    o_receive_in <= rx;
  endtask

  // both phases held long enough to pass the design's pin filter
  task automatic pulse_clock(input int n);
    repeat (n) begin
      @(posedge i_clk);
      o_shift_clock <= 1'b1;
      repeat (8) @(posedge i_clk);
      o_shift_clock <= 1'b0;
      repeat (7) @(posedge i_clk);
    end
  endtask
endmodule // port_controller_model

`default_nettype wire

// ---- testbench/test_transceiver_test_modes.sv ----
`timescale 1ns/1ps
`default_nettype none

module test_transceiver_test_modes;
  localparam int STATIC_CYC = 200; // shortened static timeout

  logic       clk, reset, sel_n, sclk, rx, ref_in, nmode, active, osc_off, cfg_wr;
  logic       float_mode, force_act, tx_oe, bosc, bosc_oe, c4, c4_oe, master;
  logic [7:0] force_byte, cfg_byte, drive_en, pin_oe, cap;
  logic [3:0] fsel;
  logic [1:0] fquat, tx_quat;
  int         fails, check_count, cycles;

  transceiver_test_modes #(
    .REF_NOMINAL_CYCLES(100), .REF_OVERRANGE_CYCLES(99), .REF_STATIC_CYCLES(STATIC_CYC)
  ) i_transceiver_test_modes (
    .i_clk(clk), .i_reset(reset), .i_port_select_n(sel_n), .i_port_shift_clock(sclk),
    .i_port_receive_in(rx), .i_trim_reference_in(ref_in), .i_network_side_mode(nmode),
    .i_transceiver_active(active), .i_buffered_osc_off(osc_off), .i_transmit_force_byte(force_byte),
    .i_link_config_byte(cfg_byte), .i_link_config_wr(cfg_wr), .i_pin_drive_en(drive_en),
    .i_framer_quat(fquat), .o_all_outputs_float_mode(float_mode), .o_pin_oe(pin_oe),
    .o_force_active(force_act), .o_framer_select(fsel), .o_tx_quat(tx_quat), .o_tx_oe(tx_oe),
    .o_cap_array(cap), .o_buffered_osc_out(bosc), .o_buffered_osc_oe(bosc_oe),
    .o_clk_4096_out(c4), .o_clk_4096_oe(c4_oe), .o_tdm_link_master(master)
  );
  port_controller_model i_ctl (.i_clk(clk), .o_select_n(sel_n), .o_shift_clock(sclk), .o_receive_in(rx));

  always #2.5 clk = ~clk;

  // tones take most of the run; the ceiling leaves about a third spare
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      fails++;
      conclude();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t %s: saw %h expected %h", $time, what, seen, exp);
    end
  endtask

  // waits end on a falling edge so outputs have settled
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic conclude();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic role_write(input logic [7:0] b, input int n, input logic exp);
    @(posedge clk);
    cfg_byte <= b;
    cfg_wr   <= 1'b1;
    repeat (n) @(posedge clk);
    cfg_wr <= 1'b0;
    step(2);
    check(8'(master), 8'(exp), "link role");
  endtask

  task automatic t_float();
    i_ctl.set_pins(1'b0, 1'b1);
    i_ctl.pulse_clock(32);
    step(10);
    check(8'(float_mode), 8'h00, "float after 32 edges");
    i_ctl.pulse_clock(1);
    step(8);
    check(8'(float_mode), 8'h01, "float after 33 edges");
    check(pin_oe, 8'h00, "pin enables in float");
    check(8'({tx_oe, bosc_oe, c4_oe}), 8'h00, "enables in float");
    i_ctl.set_pins(1'b1, 1'b1);
    drive_en <= 8'h3c;
    step(8);
    check(8'(float_mode), 8'h00, "select rose");
    check(pin_oe, drive_en, "pin enables restored");
  endtask

  // a receive dip mid-count must start the count again
  task automatic t_restart();
    i_ctl.set_pins(1'b0, 1'b1);
    i_ctl.pulse_clock(20);
    i_ctl.set_pins(1'b0, 1'b0);
    step(6);
    i_ctl.set_pins(1'b0, 1'b1);
    i_ctl.pulse_clock(20);
    step(8);
    check(8'(float_mode), 8'h00, "float after broken count");
    i_ctl.pulse_clock(13);
    step(8);
    check(8'(float_mode), 8'h01, "float after full count");
    i_ctl.set_pins(1'b0, 1'b0);
    step(8);
    check(8'(float_mode), 8'h00, "receive fell");
    i_ctl.set_pins(1'b1, 1'b1);
  endtask

  // one sample per symbol; hi count and changes fix the tone's shape
  task automatic tone(input logic [7:0] b, input logic [1:0] hi, input logic [1:0] lo, input int trans);
    int         n_hi = 0;
    int         n_tr = 0;
    logic [1:0] prev;
    @(posedge clk);
    force_byte <= b;
    step(3);
    prev = tx_quat;
    for (int i = 0; i < 8; i++) begin
      step(2500);
      if (tx_quat === hi) n_hi++;
      else if (tx_quat !== lo) n_hi += 20;
      if (tx_quat !== prev) n_tr++;
      prev = tx_quat;
    end
    check(8'(n_hi), 8'd4, "tone level balance");
    check(8'(n_tr), 8'(trans), "tone symbol changes");
  endtask

  task automatic t_force();
    for (int s = 0; s < 12; s++) begin
      @(posedge clk);
      force_byte <= 8'h80 | 8'(s);
      step(3);
      check(8'(force_act), 8'h01, "force flag");
      check(8'(fsel), 8'(s), "forced signal select");
    end
    tone(8'h89, 2'h2, 2'h0, 2);
    tone(8'h8a, 2'h2, 2'h0, 8);
    tone(8'h8b, 2'h3, 2'h1, 8);
    @(posedge clk);
    force_byte <= 8'h00;
    fquat      <= 2'h2;
    step(4);
    check(8'(force_act), 8'h00, "force released");
    check(8'(tx_quat), 8'(fquat), "framer path restored");
  endtask

  task automatic t_trim();
    @(posedge clk);
    nmode <= 1'b1;
    step(3);
    check(cap, 8'hff, "trim held while active");
    @(posedge clk);
    active <= 1'b0;
    step(3);
    check(cap, 8'h80, "trim centered");
    @(posedge clk);
    nmode <= 1'b0;
    step(STATIC_CYC + 20);
    check(cap, 8'hff, "trim with static reference");
    repeat (12) begin
      repeat (25) @(posedge clk);
      ref_in <= ~ref_in;
    end
    step(6);
    check(cap, 8'h00, "trim with fast reference");
  endtask

  task automatic t_osc();
    int   nb = 0;
    int   nc = 0;
    logic pb = bosc;
    logic pc = c4;
    repeat (1000) begin
      step(1);
      nb += int'(bosc && !pb);
      nc += int'(c4 && !pc);
      pb = bosc;
      pc = c4;
    end
    check(8'(nb >= 101 && nb <= 104), 8'h01, "oscillator copy rate");
    check(8'(nc >= 19 && nc <= 22), 8'h01, "4096 kHz clock rate");
    check(8'({bosc_oe, c4_oe}), 8'h03, "clock pins enabled");
    @(posedge clk);
    osc_off <= 1'b1;
    step(4);
    check(8'({bosc_oe, c4_oe}), 8'h01, "osc copy off");
  endtask

  initial begin
    clk         = 1'b0;
    reset       = 1'b1;
    ref_in      = 1'b0;
    nmode       = 1'b0;
    active      = 1'b1;
    osc_off     = 1'b0;
    cfg_wr      = 1'b0;
    cfg_byte    = 8'h00;
    force_byte  = 8'h00;
    drive_en    = 8'ha5;
    fquat       = 2'h1;
    fails       = 0;
    check_count = 0;
    cycles      = 0;
    step(11);
    @(posedge clk);
    reset <= 1'b0;
    step(4);
    role_write(8'h02, 1, 1'b0);
    role_write(8'h00, 1, 1'b0);
    role_write(8'h02, 2, 1'b0);
    role_write(8'h02, 1, 1'b1);
    t_float();
    t_restart();
    t_force();
    t_trim();
    t_osc();
    conclude();
  end
endmodule // test_transceiver_test_modes

`default_nettype wire
